// file: hw/ccp_pkg.sv
/*
 * Shared constants of the capture/compare/PWM unit: register offsets,
 * field positions, reset values, mode codes and timebase figures.
 * Assumes a single system clock and the unit's plain register port.
 */
package ccp_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [2:0] ADDR_CONTROL     = 3'h0;
   localparam logic [2:0] ADDR_VALUE_LOW   = 3'h1;
   localparam logic [2:0] ADDR_VALUE_HIGH  = 3'h2;
   localparam logic [2:0] ADDR_PERIOD      = 3'h3;
   localparam logic [2:0] ADDR_TB_CONTROL  = 3'h4;
   localparam logic [2:0] ADDR_STATUS      = 3'h5;
   localparam logic [2:0] ADDR_TB_COUNT    = 3'h6;

   // ==========================================================
   // Field positions
   localparam int CTRL_EN_BIT      = 7;
   localparam int CTRL_OUT_BIT     = 5;
   localparam int CTRL_FMT_BIT     = 4;
   localparam int TBC_ON_BIT       = 7;
   localparam int TBC_POST_LSB     = 3;
   localparam int TBC_PRE_LSB      = 0;
   localparam int STAT_FLAG_BIT    = 0;
   localparam int STAT_ENABLE_BIT  = 1;
   localparam int STAT_TB_FLAG_BIT = 2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] VALUE_RESET      = 8'h00;
   localparam logic [7:0] PERIOD_RESET     = 8'hff;
   localparam logic [7:0] TB_CONTROL_RESET = 8'h00;

   // ==========================================================
   // Mode select codes
   localparam logic [3:0] MODE_OFF          = 4'h0;
   localparam logic [3:0] MODE_CMP_TGL_RST  = 4'h1;
   localparam logic [3:0] MODE_CMP_TGL      = 4'h2;
   localparam logic [3:0] MODE_CAP_EVERY    = 4'h3;
   localparam logic [3:0] MODE_CAP_FALL     = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE     = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4    = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16   = 4'h7;
   localparam logic [3:0] MODE_CMP_SET      = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR      = 4'h9;
   localparam logic [3:0] MODE_CMP_PULSE    = 4'ha;
   localparam logic [3:0] MODE_CMP_PULSE_RST = 4'hb;
   localparam logic [3:0] MODE_PWM          = 4'hf;

   // ==========================================================
   // Capture prescale terminal counts and timebase figures
   localparam logic [3:0] CAP_LAST4   = 4'h3;
   localparam logic [3:0] CAP_LAST16  = 4'hf;
   localparam logic [1:0] PHASE_LAST  = 2'h3;
   localparam logic [5:0] PRE_LAST_1  = 6'h00;
   localparam logic [5:0] PRE_LAST_4  = 6'h03;
   localparam logic [5:0] PRE_LAST_16 = 6'h0f;
   localparam logic [5:0] PRE_LAST_64 = 6'h3f;

endpackage

// file: hw/pwm_timebase.sv
/*
 * Eight-bit period timebase with instruction-rate phase, prescaler and
 * output postscaler. Assumes mclk is the oscillator clock itself.
 */
`timescale 1ns/10ps
module pwm_timebase
   import ccp_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Configuration
   input  wire logic       tb_on,
   input  wire logic [1:0] prescale_sel,
   input  wire logic [3:0] postscale_sel,
   input  wire logic [7:0] period_limit,
   input  wire logic       sleep,
   // Timebase state
   output logic [7:0]      count,
   output logic [1:0]      low_bits,
   output logic            rollover,
   output logic            match_event
);

   // ==========================================================
   // Phase and prescaler
   logic [1:0] phase;
   logic [5:0] pre;
   logic [3:0] post;
   logic [5:0] pre_last;
   wire        run       = tb_on & ~sleep;
   wire        inst_tick = run & (phase == PHASE_LAST);
   wire        tick      = inst_tick & (pre == pre_last);
   wire        at_limit  = (count == period_limit);

   always_comb begin
      case (prescale_sel)
         2'h0:    pre_last = PRE_LAST_1;
         2'h1:    pre_last = PRE_LAST_4;
         2'h2:    pre_last = PRE_LAST_16;
         default: pre_last = PRE_LAST_64;
      endcase
   end

   // Low bits: clock phase at 1:1, else the prescaler's top two bits
   always_comb begin
      case (prescale_sel)
         2'h0:    low_bits = phase;
         2'h1:    low_bits = pre[1:0];
         2'h2:    low_bits = pre[3:2];
         default: low_bits = pre[5:4];
      endcase
   end

   assign rollover    = tick & at_limit;
   // Postscaler only paces the flag, never the period
   assign match_event = rollover & (post == postscale_sel);

   // ==========================================================
   // Counters
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 2'h0;
         pre   <= 6'h00;
         count <= 8'h00;
         post  <= 4'h0;
      end else if (!tb_on) begin
         phase <= 2'h0;
         pre   <= 6'h00;
         post  <= 4'h0;
      end else if (run) begin
         phase <= phase + 2'h1;
         // Greater-or-equal recovers at once when a smaller ratio is picked mid-count
         if (inst_tick)
            pre <= (pre >= pre_last) ? 6'h00 : pre + 6'h01;
         if (tick)
            count <= at_limit ? 8'h00 : count + 8'h01;
         if (rollover)
            post <= (post >= postscale_sel) ? 4'h0 : post + 4'h1;
      end
   end

endmodule

// file: hw/capture_compare_pwm_unit.sv
/*
 * Capture/compare/PWM unit: capture edge prescaler, 16-bit compare with
 * output, flag and conversion trigger actions, and 10-bit PWM on an
 * internal 8-bit timebase. Assumes the 16-bit companion timer lives
 * outside and presents its count synchronously to mclk.
 */
`timescale 1ns/10ps

module capture_compare_pwm_unit
   import ccp_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Capture source
   input  wire logic        capture_in,
   // Companion 16-bit timer
   input  wire logic [15:0] sixteen_bit_timer,
   input  wire logic        timer_ext_clock,
   output logic             sixteen_bit_timer_reset,
   // Power
   input  wire logic        sleep,
   output logic             wake_request,
   // Conversion trigger
   input  wire logic        conv_source_select,
   output logic             conv_trigger,
   // Unit output and flags
   output logic             unit_out,
   output logic             unit_irq_flag,
   output logic             timebase_match_flag
);

   // ==========================================================
   // Register state
   logic       unit_enable;
   logic       duty_alignment_bit;
   logic [3:0] unit_mode_select;
   logic [7:0] compare_value_low;
   logic [7:0] compare_value_high;
   logic [7:0] period_limit;
   logic [7:0] timebase_control_reg;
   logic       unit_irq_enable;

   // ==========================================================
   // Internal state
   logic [3:0] cap_count;
   logic       cap_prev;
   logic       match_prev;
   logic       pulse_active;
   logic       reset_armed;
   logic [9:0] duty_buffer;
   logic [7:0] pwm_timebase_count;
   logic [1:0] tb_low_bits;
   logic       tb_rollover;
   logic       tb_match_event;
   logic       pwm_start;

   // ==========================================================
   // Register decode
   wire wr_control = reg_wr & (reg_addr == ADDR_CONTROL);
   wire wr_low     = reg_wr & (reg_addr == ADDR_VALUE_LOW);
   wire wr_high    = reg_wr & (reg_addr == ADDR_VALUE_HIGH);
   wire wr_period  = reg_wr & (reg_addr == ADDR_PERIOD);
   wire wr_tbc     = reg_wr & (reg_addr == ADDR_TB_CONTROL);
   wire wr_status  = reg_wr & (reg_addr == ADDR_STATUS);
   wire wr_ctrl_zero = wr_control & (reg_wdata == 8'h00);

   // ==========================================================
   // Mode decode
   wire is_capture = unit_enable & (unit_mode_select >= MODE_CAP_EVERY)
                     & (unit_mode_select <= MODE_CAP_RISE16);
   wire is_cmp_tgl = (unit_mode_select == MODE_CMP_TGL_RST)
                     | (unit_mode_select == MODE_CMP_TGL);
   wire is_cmp_hi  = (unit_mode_select >= MODE_CMP_SET)
                     & (unit_mode_select <= MODE_CMP_PULSE_RST);
   wire is_compare = unit_enable & (is_cmp_tgl | is_cmp_hi);
   wire is_pulse   = (unit_mode_select == MODE_CMP_PULSE)
                     | (unit_mode_select == MODE_CMP_PULSE_RST);
   wire resets_tmr = (unit_mode_select == MODE_CMP_TGL_RST)
                     | (unit_mode_select == MODE_CMP_PULSE_RST);
   wire is_pwm     = unit_enable & (unit_mode_select == MODE_PWM);

   // Sleep only stops capture and compare when the companion timer is on the system clock; the PWM timebase stops on any sleep
   wire timer_alive = ~sleep | timer_ext_clock;

   // ==========================================================
   // Capture edge and prescale
   wire rise_edge = capture_in & ~cap_prev;
   wire fall_edge = ~capture_in & cap_prev;
   wire use_pre   = (unit_mode_select == MODE_CAP_RISE4)
                    | (unit_mode_select == MODE_CAP_RISE16);
   wire [3:0] cap_last = (unit_mode_select == MODE_CAP_RISE4) ? CAP_LAST4 : CAP_LAST16;
   logic raw_edge;

   always_comb begin
      case (unit_mode_select)
         MODE_CAP_EVERY:  raw_edge = rise_edge | fall_edge;
         MODE_CAP_FALL:   raw_edge = fall_edge;
         MODE_CAP_RISE,
         MODE_CAP_RISE4,
         MODE_CAP_RISE16: raw_edge = rise_edge;
         default:         raw_edge = 1'b0;
      endcase
   end

   wire cap_qualified = is_capture & timer_alive & raw_edge;
   wire cap_event     = cap_qualified & (~use_pre | (cap_count == cap_last));

   // ==========================================================
   // Compare match
   wire [15:0] compare_value = {compare_value_high, compare_value_low};
   wire match     = (compare_value == sixteen_bit_timer);
   // Timer holds a value for several clocks; act on the first only
   wire cmp_event = is_compare & timer_alive & match & ~match_prev;

   // ==========================================================
   // PWM duty and timebase
   wire [9:0] duty_word = duty_alignment_bit
                          ? {compare_value_high, compare_value_low[7:6]}
                          : {compare_value_high[1:0], compare_value_low};
   wire [9:0] tb_ten    = {pwm_timebase_count, tb_low_bits};
   wire pwm_load     = is_pwm & tb_rollover;
   wire tb_at_duty   = (tb_ten == duty_buffer);
   wire pwm_clear    = is_pwm & tb_at_duty;
   // Clear lands one clock after equality, so the set waits one clock too
   wire pwm_begin    = is_pwm & pwm_start;
   wire duty_nonzero = (duty_buffer != 10'h000);

   // ==========================================================
   // Output latch next value
   logic next_out;

   always_comb begin
      next_out = unit_out;
      if (wr_ctrl_zero || !unit_enable) begin
         next_out = 1'b0;
      end else if (cmp_event) begin
         case (unit_mode_select)
            MODE_CMP_TGL_RST,
            MODE_CMP_TGL:       next_out = ~unit_out;
            MODE_CMP_SET:       next_out = 1'b1;
            MODE_CMP_CLR:       next_out = 1'b0;
            MODE_CMP_PULSE,
            MODE_CMP_PULSE_RST: next_out = 1'b1;
            default:            next_out = unit_out;
         endcase
      end else if (pulse_active) begin
         next_out = 1'b0;
      end else if (pwm_begin) begin
         next_out = duty_nonzero;
      end else if (pwm_clear) begin
         next_out = 1'b0;
      end
   end

   // ==========================================================
   // Read mux
   logic [7:0] read_value;

   always_comb begin
      case (reg_addr)
         ADDR_CONTROL:    read_value = {unit_enable, 1'b0, unit_out, duty_alignment_bit,
                                        unit_mode_select};
         ADDR_VALUE_LOW:  read_value = compare_value_low;
         ADDR_VALUE_HIGH: read_value = compare_value_high;
         ADDR_PERIOD:     read_value = period_limit;
         ADDR_TB_CONTROL: read_value = timebase_control_reg;
         ADDR_STATUS:     read_value = {5'h00, timebase_match_flag, unit_irq_enable,
                                        unit_irq_flag};
         ADDR_TB_COUNT:   read_value = pwm_timebase_count;
         default:         read_value = 8'h00;
      endcase
   end

   // Flags: a hardware set in the clearing cycle survives the clear
   wire flag_clear   = wr_status & ~reg_wdata[STAT_FLAG_BIT];
   wire tbflag_clear = wr_status & ~reg_wdata[STAT_TB_FLAG_BIT];
   wire flag_set     = cap_event | cmp_event | pwm_load;
   wire next_flag    = flag_set | (unit_irq_flag & ~flag_clear);
   wire next_tbflag  = tb_match_event | (timebase_match_flag & ~tbflag_clear);

   // ==========================================================
   // Control and configuration registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unit_enable          <= CONTROL_RESET[CTRL_EN_BIT];
         duty_alignment_bit   <= CONTROL_RESET[CTRL_FMT_BIT];
         unit_mode_select     <= CONTROL_RESET[3:0];
         period_limit         <= PERIOD_RESET;
         timebase_control_reg <= TB_CONTROL_RESET;
         unit_irq_enable      <= 1'b0;
      end else begin
         if (wr_control) begin
            unit_enable        <= reg_wdata[CTRL_EN_BIT];
            duty_alignment_bit <= reg_wdata[CTRL_FMT_BIT];
            unit_mode_select   <= reg_wdata[3:0];
         end
         if (wr_period)
            period_limit <= reg_wdata;
         if (wr_tbc)
            timebase_control_reg <= reg_wdata;
         if (wr_status)
            unit_irq_enable <= reg_wdata[STAT_ENABLE_BIT];
      end
   end

   // Value pair: a capture beats a software write in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         compare_value_low  <= VALUE_RESET;
         compare_value_high <= VALUE_RESET;
      end else if (cap_event) begin
         compare_value_low  <= sixteen_bit_timer[7:0];
         compare_value_high <= sixteen_bit_timer[15:8];
      end else begin
         if (wr_low)
            compare_value_low <= reg_wdata;
         if (wr_high)
            compare_value_high <= reg_wdata;
      end
   end

   // ==========================================================
   // Capture prescaler counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_count <= 4'h0;
         cap_prev  <= 1'b0;
      end else begin
         cap_prev <= capture_in;
         if (!is_capture)
            cap_count <= 4'h0;
         else if (cap_qualified && use_pre)
            cap_count <= (cap_count == cap_last) ? 4'h0 : cap_count + 4'h1;
      end
   end

   // ==========================================================
   // Compare sequencing, output and PWM buffer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         match_prev   <= 1'b0;
         pulse_active <= 1'b0;
         reset_armed  <= 1'b0;
         unit_out     <= 1'b0;
         duty_buffer  <= 10'h000;
      end else begin
         match_prev   <= match;
         pulse_active <= cmp_event & is_pulse;
         reset_armed  <= cmp_event & resets_tmr;
         unit_out     <= next_out;
         if (pwm_load)
            duty_buffer <= duty_word;
      end
   end

   // ==========================================================
   // PWM period start
   // One clock behind the rollover, lined up with the clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_start <= 1'b0;
      end else begin
         pwm_start <= pwm_load;
      end
   end

   // ==========================================================
   // Trigger, timer reset and flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         conv_trigger            <= 1'b0;
         sixteen_bit_timer_reset <= 1'b0;
         unit_irq_flag           <= 1'b0;
         timebase_match_flag     <= 1'b0;
         reg_rdata               <= 8'h00;
      end else begin
         conv_trigger            <= cmp_event & conv_source_select;
         // Reset fires one edge after the trigger only if match still holds
         sixteen_bit_timer_reset <= reset_armed & match;
         unit_irq_flag           <= next_flag;
         timebase_match_flag     <= next_tbflag;
         reg_rdata               <= reg_rd ? read_value : 8'h00;
      end
   end

   // ==========================================================
   // Wake request
   // Level, so a wake stays asked for until software clears the flag
   assign wake_request = unit_irq_flag & unit_irq_enable;

   // ==========================================================
   // PWM timebase
   pwm_timebase u_timebase (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .tb_on         (timebase_control_reg[TBC_ON_BIT]),
      .prescale_sel  (timebase_control_reg[TBC_PRE_LSB +: 2]),
      .postscale_sel (timebase_control_reg[TBC_POST_LSB +: 4]),
      .period_limit  (period_limit),
      .sleep         (sleep),
      .count         (pwm_timebase_count),
      .low_bits      (tb_low_bits),
      .rollover      (tb_rollover),
      .match_event   (tb_match_event)
   );

endmodule

// file: sim/ccp_props.sv
/*
 * Port checker for the capture/compare/PWM unit.
 * Assumes the single mclk domain and the plain register port.
 */
`timescale 1ns/10ps
module ccp_props
   import ccp_pkg::*;
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Events and outputs
   input wire logic       conv_source_select,
   input wire logic       conv_trigger,
   input wire logic       sixteen_bit_timer_reset,
   input wire logic       wake_request,
   input wire logic       unit_out,
   input wire logic       unit_irq_flag
);
   // ======================================
   // Mode shadow, tracks control writes
   logic [3:0] mode_q;
   wire        ctrl_wr = reg_wr && reg_addr == ADDR_CONTROL;
   wire        pulse_mode = mode_q == MODE_CMP_PULSE || mode_q == MODE_CMP_PULSE_RST;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_OFF;
      end else if (ctrl_wr) begin
         mode_q <= reg_wdata[3:0];
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ======================================
   // Properties
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   AST_TRIG_ONE: assert property (conv_trigger |=> !conv_trigger)
      else $error("trigger longer than one cycle");
   AST_TRIG_FLAG: assert property (conv_trigger |-> unit_irq_flag)
      else $error("trigger without flag");
   AST_TRIG_SEL: assert property (conv_trigger |-> $past(conv_source_select))
      else $error("trigger while not selected");
   AST_TRST_AFTER_TRIG: assert property
      (sixteen_bit_timer_reset && $past(conv_source_select, 2) |-> $past(conv_trigger))
      else $error("timer reset without preceding trigger");
   AST_TRST_MODE: assert property
      (sixteen_bit_timer_reset |-> mode_q == MODE_CMP_TGL_RST || mode_q == MODE_CMP_PULSE_RST)
      else $error("timer reset in wrong mode");
   AST_PULSE_ONE: assert property (pulse_mode && $rose(unit_out) |=> !unit_out)
      else $error("pulse longer than one cycle");
   AST_ZERO_CTRL: assert property (ctrl_wr && reg_wdata == 8'h00 |=> !unit_out)
      else $error("output not low after control cleared");
   AST_WAKE: assert property (wake_request |-> unit_irq_flag)
      else $error("wake without flag");
endmodule
bind capture_compare_pwm_unit ccp_props u_ccp_props (.mclk, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .conv_source_select, .conv_trigger, .sixteen_bit_timer_reset,
   .wake_request, .unit_out, .unit_irq_flag);

// file: sim/timer_model.sv
/*
 * Companion 16-bit timer, counting at a quarter of mclk.
 * Assumes the unit's reset request is a one-cycle pulse.
 */
`timescale 1ns/10ps
module timer_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        sleep,
   input  wire logic        ext_clk,
   input  wire logic        clear,
   // Count
   output logic [15:0]      count,
   output logic [1:0]       phase
);
   // Synchronous, quarter rate, never the full clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
         phase <= 2'h0;
      end else if (clear) begin
         count <= 16'h0000;
         phase <= 2'h0;
      end else if (!sleep || ext_clk) begin
         phase <= phase + 2'h1;
         count <= count + 16'(phase == 2'h3);
      end
   end
endmodule

// file: sim/tb_top.sv
/*
 * Self-checking bench for the capture/compare/PWM unit.
 * Assumes timer_model as the companion timer.
 */
`timescale 1ns/10ps
module tb_top;
   import ccp_pkg::*;
   logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, capture_in = 0;
   logic        sleep = 0, ext_clk = 0, conv_sel = 1, saw_trig, saw_rst;
   logic [2:0]  reg_addr = 3'h0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd_val;
   logic [15:0] tmr, stamp;
   logic [1:0]  ph;
   logic        unit_out, flag, tb_flag, trig, trst, wake;
   int          failures = 0, n_tests = 0;
   localparam logic [3:0] MODES [6] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_TGL,
      MODE_CMP_PULSE, MODE_CMP_PULSE_RST, MODE_CMP_TGL_RST};
   localparam logic [5:0] OUTS = 6'h25, RSTS = 6'h30;
   capture_compare_pwm_unit u_capture_compare_pwm_unit (.mclk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .capture_in, .sixteen_bit_timer(tmr),
      .timer_ext_clock(ext_clk), .sixteen_bit_timer_reset(trst), .sleep, .wake_request(wake),
      .conv_source_select(conv_sel), .conv_trigger(trig), .unit_out,
      .unit_irq_flag(flag), .timebase_match_flag(tb_flag));
   timer_model u_timer_model (.mclk, .rst_n, .sleep, .ext_clk, .clear(trst), .count(tmr),
      .phase(ph));
   initial forever #50 mclk = ~mclk;
   // =================================
   // Shared tasks
   task automatic close_out;
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      rd_val = reg_rdata;
   endtask
   task automatic wait_flag(input int bound);
      int i;
      saw_trig = 0;
      saw_rst = 0;
      for (i = 0; i < bound && flag !== 1'b1; i++) begin
         @(posedge mclk);
         saw_trig |= trig;
      end
      if (i == bound) begin
         failures++;
         close_out();
      end
      repeat (3) begin
         @(posedge mclk);
         saw_rst |= trst;
      end
   endtask
   task automatic cap_edges(input int n);
      repeat (n) begin
         @(posedge mclk);
         capture_in <= 1'b1;
         @(posedge mclk);
         stamp = tmr;
         capture_in <= 1'b0;
      end
      repeat (2) @(posedge mclk);
   endtask
   // =================================
   // Scenarios
   task automatic t_compare(input logic [3:0] mode, input logic exp_out, input logic exp_rst);
      logic [15:0] val;
      val = tmr + 16'h0010;
      wr(ADDR_VALUE_LOW, val[7:0]);
      wr(ADDR_VALUE_HIGH, val[15:8]);
      wr(ADDR_CONTROL, {4'h8, mode});
      wait_flag(200);
      chk(unit_out, exp_out);
      chk(saw_trig, 1'b1);
      chk(saw_rst, exp_rst);
      chk(wake, sleep);
      wr(ADDR_STATUS, 8'h00);
   endtask
   task automatic t_no_reset;
      logic [15:0] val;
      int i;
      wr(ADDR_CONTROL, {4'h8, MODE_CMP_TGL_RST});
      val = tmr + 16'h0008;
      wr(ADDR_VALUE_LOW, val[7:0]);
      wr(ADDR_VALUE_HIGH, val[15:8]);
      for (i = 0; i < 200 && !(tmr === val - 16'h0001 && ph === 2'h3); i++) @(posedge mclk);
      chk(16'(i < 200), 16'h0001);
      reg_addr <= ADDR_VALUE_LOW;
      reg_wdata <= val[7:0] ^ 8'h80;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      wait_flag(10);
      chk(saw_rst, 1'b0);
      chk(saw_trig, 1'b0);
      chk(unit_out, 1'b1);
      wr(ADDR_STATUS, 8'h00);
   endtask
   task automatic t_edge(input logic [3:0] mode, input logic exp_r, exp_f);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, {4'h8, mode});
      wr(ADDR_STATUS, 8'h00);
      capture_in <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(flag, exp_r);
      wr(ADDR_STATUS, 8'h00);
      capture_in <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(flag, exp_f);
   endtask
   task automatic t_pwm(input logic [7:0] tbc, ctl, hi, lo, input int period, high);
      int h;
      wr(ADDR_VALUE_LOW, lo);
      wr(ADDR_VALUE_HIGH, hi);
      wr(ADDR_CONTROL, ctl);
      wr(ADDR_TB_CONTROL, tbc);
      repeat (2 * period) @(posedge mclk);
      h = 0;
      repeat (4 * period) begin
         @(posedge mclk);
         h += unit_out;
      end
      chk(16'(h), 16'(4 * high));
   endtask
   // =================================
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ADDR_PERIOD);
      chk(rd_val, PERIOD_RESET);
      rd(3'h7);
      chk(rd_val, 8'h00);
      for (int k = 0; k < 6; k++) begin
         sleep <= k == 0;
         ext_clk <= k == 0;
         wr(ADDR_STATUS, {6'h00, k == 0, 1'b0});
         t_compare(MODES[k], OUTS[k], RSTS[k]);
      end
      sleep <= 1'b0;
      ext_clk <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      @(posedge mclk);
      chk(unit_out, 1'b0);
      conv_sel <= 1'b0;
      t_no_reset();
      wr(ADDR_CONTROL, {4'h8, MODE_CAP_RISE4});
      wr(ADDR_STATUS, 8'h00);
      cap_edges(3);
      chk(flag, 1'b0);
      cap_edges(1);
      chk(flag, 1'b1);
      wr(ADDR_STATUS, 8'h00);
      cap_edges(2);
      wr(ADDR_CONTROL, {4'h8, MODE_CAP_RISE16});
      wr(ADDR_STATUS, 8'h00);
      cap_edges(13);
      chk(flag, 1'b0);
      cap_edges(1);
      chk(flag, 1'b1);
      rd(ADDR_VALUE_LOW);
      chk(rd_val, stamp[7:0]);
      cap_edges(2);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, {4'h8, MODE_CAP_RISE4});
      wr(ADDR_STATUS, 8'h00);
      cap_edges(3);
      chk(flag, 1'b0);
      cap_edges(1);
      chk(flag, 1'b1);
      t_edge(MODE_CAP_EVERY, 1'b1, 1'b1);
      t_edge(MODE_CAP_FALL, 1'b0, 1'b1);
      t_edge(MODE_CAP_RISE, 1'b1, 1'b0);
      wr(ADDR_PERIOD, 8'h03);
      wr(ADDR_STATUS, 8'h00);
      t_pwm(8'h80, 8'h8f, 8'h00, 8'h06, 16, 6);
      chk(tb_flag, 1'b1);
      t_pwm(8'hf8, 8'h9f, 8'h02, 8'h80, 16, 10);
      t_pwm(8'h81, 8'h8f, 8'h00, 8'h0a, 64, 40);
      t_pwm(8'h80, 8'h8f, 8'h00, 8'h00, 16, 0);
      close_out();
   end
endmodule
